//--- rtl/rtd_cfg.svh
// Constants of the remote-terminal descriptor engine.
// Assumes 16-bit shared RAM words and a 125 MHz master clock.
`ifndef RTD_CFG_SVH
`define RTD_CFG_SVH

// ------------------------------------------------------------
// Descriptor control word fields
// ------------------------------------------------------------
`define CW_ILL_BC      10
`define CW_ILL         9
`define CW_IRQ_CMD     8
`define CW_IRQ_ZERO    7
`define CW_IDX_HI      6
`define CW_IDX_LO      0
`define IDX_ZERO       7'h00
`define IDX_ONE        7'h01

// ------------------------------------------------------------
// Message status word fields
// ------------------------------------------------------------
`define SW_SSF         15
`define SW_BC          14
`define SW_ERR         13
`define SW_WC_HI       12
`define SW_WC_LO       8
`define SW_TT_HI       7
`define SW_TT_LO       0

// ------------------------------------------------------------
// Descriptor layout: receive then transmit, four words each
// ------------------------------------------------------------
`define DESC_ADDR(sa, tx) ({8'h00, sa, tx, 2'b00})
`define DESC_CTL_OFS   16'h0000
`define DESC_MSP_OFS   16'h0001
`define DESC_DLP_OFS   16'h0002

// ------------------------------------------------------------
// Sequencing and host decode
// ------------------------------------------------------------
`define LAST_FETCH     2'h2
`define LAST_DATA      2'h0
`define LAST_UPDATE    2'h3
`define OP_STS         2'h0
`define OP_CTL         2'h1
`define OP_MSP         2'h2
`define ACC_SETUP      2'h0
`define ACC_STROBE     2'h1
`define ACC_RELEASE    2'h2
`define REG_LAST       4'hD
`define WC_FULL        6'h20

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS  8
`define TT_RES_NS      64000
`define TT_TICK_CYCLES (`TT_RES_NS / `CLK_PERIOD_NS)

`endif

//--- rtl/rtd_pkg.sv
// Types shared by the descriptor engine files.
// Assumes rtd_cfg.svh is on the include path.
package rtd_pkg;

   // ------------------------------------------------------------
   // Sequencer states and memory phases
   // ------------------------------------------------------------
   typedef enum logic [2:0] {S_IDLE, S_ACQ, S_ACC, S_MSG} st_t;
   typedef enum logic [1:0] {PH_FETCH, PH_DATA, PH_UPDATE} ph_t;

   // ------------------------------------------------------------
   // Whole state of the engine
   // ------------------------------------------------------------
   typedef struct packed {
      st_t         st;
      ph_t         ph;
      logic [1:0]  acc;
      logic [1:0]  opn;
      logic [4:0]  sa;
      logic        tx;
      logic        bc;
      logic [4:0]  wc;
      logic [15:0] ctl;
      logic [15:0] msp;
      logic [15:0] dlp;
      logic [5:0]  wtk;
      logic        ovf;
      logic        ill;
      logic        zr;
      logic [15:0] dw;
      logic [15:0] aout;
      logic [15:0] dout;
      logic        msg_err;
      logic        irq_cmd;
      logic        irq_zero;
      logic        irq_ill;
      logic        dw_done;
      logic        tx_on;
      logic        chan_b;
   } eng_t;

endpackage

//--- rtl/time_tag_timer.sv
// Free-running message time tag with a fixed tick resolution.
// Assumes a single clock; the tick is a one-cycle enable from a divider.
`timescale 1ns/100ps
module time_tag_timer #(
   parameter int TICK_CYCLES = 8000
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   output logic [7:0]      tag
);
   localparam int CW = $clog2(TICK_CYCLES + 1);

   typedef struct packed {
      logic [CW-1:0] div;
      logic [7:0]    tag;
   } tmr_t;

   tmr_t q;
   tmr_t d;

   // ------------------------------------------------------------
   // Divider and tag counter
   // ------------------------------------------------------------
   always_comb begin
      d = q;
      if (q.div == CW'(TICK_CYCLES - 1)) begin
         d.div = '0;
         d.tag = q.tag + 8'h01;
      end else begin
         d.div = q.div + CW'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tag = q.tag;

endmodule

//--- rtl/rt_descriptor_message_buffering.sv
// Remote-terminal descriptor engine with its shared-memory and host port.
// Assumes the protocol engine presents decoded commands and data words and
// that all inputs are synchronous to MCLK.
//
// How it works
// - Buses float except register read or drive
// - Host register access ignored during own access
// - Busy blocks every new memory request
// - Registers 0-13 decoded from four address lines
// - Host RAM strobes pass through when idle
// - Burst output marks consecutive memory accesses
// - Address bus driven only when enabled
// - Transmit timer and active channel outputs
// - Descriptor is four consecutive words
// - Receive then transmit descriptor per subaddress
// - Fetch descriptor words; one enables function
// - Bit 10 illegalises broadcast receive
// - Bit 9 illegalises subaddress, raises interrupt
// - Bit 8 interrupt before descriptor updates
// - Bit 7 interrupt when index reaches zero
// - Index decrements per message, stops at zero
// - Status pointer advances unless index zero
// - Errored messages still write status word
// - Data pointer advances after good message
// - Errored message leaves data pointer unchanged
// - Index zero leaves data pointer unchanged
// - One status word per message in list
// - Status word layout with time tag
// - Surplus data words flag error, not stored
`timescale 1ns/100ps
`include "rtd_cfg.svh"
module rt_descriptor_message_buffering
   import rtd_pkg::*;
#(
   parameter int TICK_CYCLES = `TT_TICK_CYCLES
) (
   input  wire logic        MCLK,
   input  wire logic        NRST,
   input  wire logic        HOST_CS_N,
   input  wire logic        HOST_RD_N,
   input  wire logic        HOST_WR_N,
   input  wire logic        HOST_RAM_SELECT_IN_N,
   input  wire logic [3:0]  HOST_ADDR,
   input  wire logic [15:0] REG_RDATA,
   output logic [3:0]       REG_INDEX,
   output logic             REG_RD_STROBE,
   output logic             REG_WR_STROBE,
   output logic [15:0]      ADDR_OUT,
   output logic             ADDR_OE,
   input  wire logic [15:0] DATA_IN,
   output logic [15:0]      DATA_OUT,
   output logic             DATA_OE,
   output logic             RAM_READ_STROBE_N,
   output logic             RAM_WRITE_STROBE_N,
   output logic             RAM_SELECT_OUT_N,
   output logic             DMA_REQUEST_OUT_N,
   input  wire logic        DMA_GRANT_IN_N,
   output logic             DMA_ACKNOWLEDGE_OUT_N,
   output logic             BUS_DRIVE_INDICATOR_N,
   input  wire logic        ADDRESS_DRIVE_ENABLE_N,
   output logic             BURST_N,
   input  wire logic        RT_BUSY,
   input  wire logic [15:0] DESC_BASE,
   input  wire logic        SUBSYSTEM_FAIL_IN,
   input  wire logic        ILL_IRQ_ENABLE,
   input  wire logic        TX_ACTIVE,
   input  wire logic        RX_CHANNEL_B,
   output logic             TRANSMIT_TIMER_ON,
   output logic             ACTIVE_CHANNEL_FLAG,
   output logic             MSG_READY,
   input  wire logic        MSG_START,
   input  wire logic [4:0]  MSG_SUBADDR,
   input  wire logic        MSG_TRANSMIT,
   input  wire logic        MSG_BROADCAST,
   input  wire logic [4:0]  MSG_WORD_COUNT,
   output logic             DW_READY,
   input  wire logic        DW_REQ,
   input  wire logic [15:0] DW_IN,
   output logic             DW_DONE,
   output logic [15:0]      DW_OUT,
   input  wire logic        MSG_END,
   input  wire logic        MSG_ERR_IN,
   output logic             STATUS_MSG_ERROR,
   output logic             IRQ_CMD,
   output logic             IRQ_INDEX_ZERO,
   output logic             IRQ_ILLEGAL
);

   eng_t        q;
   eng_t        d;
   logic [7:0]  tag;
   logic        own;
   logic        host_rd;
   logic        op_wr;
   logic        last_op;
   logic [1:0]  last_n;
   logic [15:0] daddr;
   logic [15:0] op_addr;
   logic [15:0] op_wdata;
   logic [5:0]  wc_n;
   logic [15:0] msp_next;
   logic [6:0]  idx;

   time_tag_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_timer (
      .clk   (MCLK),
      .rst_n (NRST),
      .tag   (tag)
   );

   // ------------------------------------------------------------
   // Memory operation decode
   // ------------------------------------------------------------
   // four-word descriptor
   assign daddr    = DESC_BASE + `DESC_ADDR(q.sa, q.tx);
   assign idx      = q.ctl[`CW_IDX_HI:`CW_IDX_LO];
   assign wc_n     = (q.wc == 5'h00) ? `WC_FULL : {1'b0, q.wc};
   assign msp_next = q.zr ? q.msp : q.msp + 16'h0001;
   assign own      = (q.st == S_ACC);
   assign host_rd  = !HOST_CS_N && !HOST_RD_N;

   always_comb begin
      op_addr  = daddr;
      op_wdata = q.dw;
      op_wr    = 1'b0;
      last_n   = `LAST_DATA;
      case (q.ph)
         PH_FETCH: begin
            op_addr = daddr + {14'h0000, q.opn};
            last_n  = `LAST_FETCH;
         end
         PH_DATA: begin
            op_addr = q.dlp + {10'h000, q.wtk};
            op_wr   = !q.tx;
         end
         PH_UPDATE: begin
            op_wr  = 1'b1;
            last_n = `LAST_UPDATE;
            case (q.opn)
               `OP_STS: begin
                  op_addr  = q.msp;
                  op_wdata = q.dw;
               end
               `OP_CTL: begin
                  op_addr  = daddr + `DESC_CTL_OFS;
                  op_wdata = q.ctl;
               end
               `OP_MSP: begin
                  op_addr  = daddr + `DESC_MSP_OFS;
                  op_wdata = msp_next;
               end
               default: begin
                  op_addr  = daddr + `DESC_DLP_OFS;
                  op_wdata = q.dlp;
               end
            endcase
         end
         default: begin
            op_addr = daddr;
         end
      endcase
   end

   assign last_op = (q.opn == last_n);

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      d          = q;
      d.irq_cmd  = 1'b0;
      d.irq_zero = 1'b0;
      d.irq_ill  = 1'b0;
      d.dw_done  = 1'b0;
      d.tx_on    = TX_ACTIVE;
      d.chan_b   = RX_CHANNEL_B;
      if (host_rd && !own) begin
         d.dout = REG_RDATA;
      end
      case (q.st)
         S_IDLE: begin
            if (MSG_START) begin
               d.sa      = MSG_SUBADDR;
               d.tx      = MSG_TRANSMIT;
               d.bc      = MSG_BROADCAST;
               d.wc      = MSG_WORD_COUNT;
               d.wtk     = '0;
               d.ovf     = 1'b0;
               d.msg_err = 1'b0;
               d.ph      = PH_FETCH;
               d.opn     = '0;
               d.st      = S_ACQ;
            end
         end
         S_ACQ: begin
            if (!RT_BUSY && !DMA_GRANT_IN_N) begin
               d.acc = `ACC_SETUP;
               d.st  = S_ACC;
            end
         end
         S_ACC: begin
            case (q.acc)
               `ACC_SETUP: begin
                  d.aout = op_addr;
                  if (op_wr) begin
                     d.dout = op_wdata;
                  end
                  d.acc = `ACC_STROBE;
               end
               `ACC_STROBE: begin
                  d.acc = `ACC_RELEASE;
                  if (!op_wr) begin
                     case (q.ph)
                        PH_FETCH: begin
                           case (q.opn)
                              `OP_STS: d.ctl = DATA_IN;
                              `OP_CTL: d.msp = DATA_IN;
                              default: d.dlp = DATA_IN;
                           endcase
                        end
                        default: begin
                           d.dw = DATA_IN;
                        end
                     endcase
                  end
               end
               default: begin
                  d.acc = `ACC_SETUP;
                  if (!last_op) begin
                     d.opn = q.opn + 2'h1;
                  end else begin
                     d.opn = '0;
                     case (q.ph)
                        PH_FETCH: begin
                           d.ill = q.ctl[`CW_ILL] || (q.ctl[`CW_ILL_BC] && q.bc && !q.tx);
                           d.irq_ill = q.ctl[`CW_ILL] && ILL_IRQ_ENABLE;
                           if (d.ill) begin
                              d.msg_err = 1'b1;
                           end
                           d.st = S_MSG;
                        end
                        PH_DATA: begin
                           d.wtk     = q.wtk + 6'h01;
                           d.dw_done = 1'b1;
                           d.st      = S_MSG;
                        end
                        default: begin
                           d.st = S_IDLE;
                        end
                     endcase
                  end
               end
            endcase
         end
         S_MSG: begin
            if (MSG_END) begin
               d.irq_cmd = q.ctl[`CW_IRQ_CMD] && !q.ill;
               d.irq_zero = q.ctl[`CW_IRQ_ZERO] && (idx == `IDX_ONE);
               d.zr = (idx == `IDX_ZERO);
               if (idx != `IDX_ZERO) begin
                  d.ctl[`CW_IDX_HI:`CW_IDX_LO] = idx - `IDX_ONE;
               end
               d.dw = '0;
               d.dw[`SW_SSF] = SUBSYSTEM_FAIL_IN;
               d.dw[`SW_BC]  = q.bc;
               d.dw[`SW_ERR] = MSG_ERR_IN || q.ovf || q.ill;
               d.dw[`SW_WC_HI:`SW_WC_LO] = q.wc;
               d.dw[`SW_TT_HI:`SW_TT_LO] = tag;
               if (MSG_ERR_IN || q.ovf) begin
                  d.msg_err = 1'b1;
               end
               if (!(MSG_ERR_IN || q.ovf || q.ill) && (idx != `IDX_ZERO)) begin
                  d.dlp = q.dlp + {10'h000, wc_n};
               end
               d.ph  = PH_UPDATE;
               d.opn = '0;
               d.st  = S_ACQ;
            end else if (DW_REQ) begin
               if (q.wtk == wc_n || q.ill) begin
                  d.ovf     = q.ovf || !q.ill;
                  d.dw_done = 1'b1;
               end else begin
                  d.dw  = DW_IN;
                  d.ph  = PH_DATA;
                  d.opn = '0;
                  d.st  = S_ACQ;
               end
            end
         end
         default: begin
            d.st = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ------------------------------------------------------------
   // Pins
   // ------------------------------------------------------------
   // tri-state unless reading or driving
   assign DATA_OE = (host_rd && !own) || (own && op_wr);
   assign ADDR_OE = own && !ADDRESS_DRIVE_ENABLE_N;
   assign ADDR_OUT = q.aout;
   assign DATA_OUT = q.dout;
   assign REG_INDEX     = HOST_ADDR;
   assign REG_RD_STROBE = host_rd && !own && (HOST_ADDR <= `REG_LAST);
   assign REG_WR_STROBE = !HOST_CS_N && !HOST_WR_N && !own && (HOST_ADDR <= `REG_LAST);
   assign RAM_READ_STROBE_N  = own ? !(q.acc == `ACC_STROBE && !op_wr) : HOST_RD_N;
   assign RAM_WRITE_STROBE_N = own ? !(q.acc == `ACC_STROBE && op_wr) : HOST_WR_N;
   assign RAM_SELECT_OUT_N   = own ? (q.acc != `ACC_STROBE) : HOST_RAM_SELECT_IN_N;
   assign DMA_REQUEST_OUT_N     = !(q.st == S_ACQ && !RT_BUSY);
   assign DMA_ACKNOWLEDGE_OUT_N = !own;
   assign BUS_DRIVE_INDICATOR_N = !own;
   assign BURST_N = !(own && !last_op);
   assign TRANSMIT_TIMER_ON   = q.tx_on;
   assign ACTIVE_CHANNEL_FLAG = q.chan_b;
   assign MSG_READY        = (q.st == S_IDLE);
   assign DW_READY         = (q.st == S_MSG);
   assign DW_DONE          = q.dw_done;
   assign DW_OUT           = q.dw;
   assign STATUS_MSG_ERROR = q.msg_err;
   assign IRQ_CMD          = q.irq_cmd;
   assign IRQ_INDEX_ZERO   = q.irq_zero;
   assign IRQ_ILLEGAL      = q.irq_ill;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_float;
      @(posedge MCLK) disable iff (!NRST) DATA_OE |-> (host_rd || !BUS_DRIVE_INDICATOR_N);
   endproperty
   a_float: assert property (p_float) else $error("data bus driven without cause");
   property p_reg_ign;
      @(posedge MCLK) disable iff (!NRST) !DMA_ACKNOWLEDGE_OUT_N |-> !REG_RD_STROBE && !REG_WR_STROBE;
   endproperty
   a_reg_ign: assert property (p_reg_ign) else $error("register access during memory access");
   property p_busy;
      @(posedge MCLK) disable iff (!NRST) RT_BUSY |-> DMA_REQUEST_OUT_N;
   endproperty
   a_busy: assert property (p_busy) else $error("request while busy");
   property p_decode;
      @(posedge MCLK) disable iff (!NRST) REG_RD_STROBE |-> HOST_ADDR <= `REG_LAST && REG_INDEX == HOST_ADDR;
   endproperty
   a_decode: assert property (p_decode) else $error("register index out of range");
   property p_pass;
      @(posedge MCLK) disable iff (!NRST)
         DMA_ACKNOWLEDGE_OUT_N |-> RAM_READ_STROBE_N == HOST_RD_N && RAM_SELECT_OUT_N == HOST_RAM_SELECT_IN_N;
   endproperty
   a_pass: assert property (p_pass) else $error("host strobes not passed through");
   property p_burst;
      @(posedge MCLK) disable iff (!NRST) !BURST_N |-> ##3 !DMA_ACKNOWLEDGE_OUT_N;
   endproperty
   a_burst: assert property (p_burst) else $error("burst without following access");
   property p_aen;
      @(posedge MCLK) disable iff (!NRST) ADDR_OE |-> !ADDRESS_DRIVE_ENABLE_N && !BUS_DRIVE_INDICATOR_N;
   endproperty
   a_aen: assert property (p_aen) else $error("address driven while disabled");
   property p_grant;
      @(posedge MCLK) disable iff (!NRST) $fell(BUS_DRIVE_INDICATOR_N) |-> $past(!DMA_GRANT_IN_N);
   endproperty
   a_grant: assert property (p_grant) else $error("drive indicator without grant");
   property p_irq_zero;
      @(posedge MCLK) disable iff (!NRST) IRQ_INDEX_ZERO |-> ##[1:40] (q.ph == PH_UPDATE && q.opn == `OP_CTL);
   endproperty
   a_irq_zero: assert property (p_irq_zero) else $error("index update missing after interrupt");
   c_update: cover property (@(posedge MCLK) disable iff (!NRST) q.st == S_ACC && q.ph == PH_UPDATE);
   c_illegal: cover property (@(posedge MCLK) disable iff (!NRST) IRQ_ILLEGAL);
   c_overflow: cover property (@(posedge MCLK) disable iff (!NRST) q.ovf && MSG_END);

endmodule

//--- verification/host_ram_model.sv
// Shared RAM and DMA arbiter standing on the far side of the engine.
// Assumes active-low strobes that are sampled at the rising clock edge.
`timescale 1ns/100ps
module host_ram_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        slow,
   input  wire logic [15:0] addr,
   input  wire logic [15:0] wdata,
   output logic [15:0]      rdata,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   input  wire logic        sel_n,
   input  wire logic        req_n,
   output logic             gnt_n
);
   logic [15:0] mem [0:255];
   logic [2:0]  dly_q;
   logic        tgl_q;

   // Outside a read the data bus shows a pattern that flips every cycle.
   assign rdata = (!sel_n && !rd_n) ? mem[addr[7:0]] : {16{tgl_q}};

   initial for (int i = 0; i < 256; i++) mem[i] = 16'h0000;

   always @(posedge clk) begin
      if (!sel_n && !wr_n) mem[addr[7:0]] <= wdata;
   end

   // A slow grant waits three cycles of steady request.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dly_q <= 3'h7;
         gnt_n <= 1'b1;
         tgl_q <= 1'b0;
      end else begin
         dly_q <= {dly_q[1:0], req_n};
         gnt_n <= slow ? (dly_q[2] | req_n) : req_n;
         tgl_q <= ~tgl_q;
      end
   end
endmodule

//--- verification/rt_descriptor_message_buffering_test.sv
// Self-checking bench for the descriptor engine.
// Assumes the RAM model above and a descriptor base of zero.
`timescale 1ns/100ps
module rt_descriptor_message_buffering_test;
   import rtd_pkg::*;
   logic MCLK, NRST, HOST_CS_N, HOST_RD_N, HOST_WR_N, HOST_RAM_SELECT_IN_N, DMA_GRANT_IN_N, RT_BUSY;
   logic SUBSYSTEM_FAIL_IN, ILL_IRQ_ENABLE, TX_ACTIVE, RX_CHANNEL_B, MSG_START, MSG_TRANSMIT, MSG_BROADCAST;
   logic DW_REQ, MSG_END, MSG_ERR_IN, REG_RD_STROBE, REG_WR_STROBE, ADDR_OE, DATA_OE, RAM_READ_STROBE_N;
   logic RAM_WRITE_STROBE_N, RAM_SELECT_OUT_N, DMA_REQUEST_OUT_N, DMA_ACKNOWLEDGE_OUT_N, BUS_DRIVE_INDICATOR_N;
   logic BURST_N, TRANSMIT_TIMER_ON, ACTIVE_CHANNEL_FLAG, MSG_READY, DW_READY, DW_DONE, STATUS_MSG_ERROR;
   logic IRQ_CMD, IRQ_INDEX_ZERO, IRQ_ILLEGAL, slow, s_cmd, s_zero, s_ill, irq_clr, ADDRESS_DRIVE_ENABLE_N;
   logic [3:0]  HOST_ADDR, REG_INDEX;
   logic [4:0]  MSG_SUBADDR, MSG_WORD_COUNT;
   logic [15:0] REG_RDATA, ADDR_OUT, DATA_IN, DATA_OUT, DESC_BASE, DW_IN, DW_OUT, dw_seen;
   int          num_errors = 0, compares = 0, cyc = 0, nmsg = 0;

   // The address drive enable is driven by the tests, so both of its levels are seen.
   rt_descriptor_message_buffering #(.TICK_CYCLES(4)) dut (.*);
   host_ram_model ram (.clk(MCLK), .rst_n(NRST), .slow(slow), .addr(ADDR_OUT), .wdata(DATA_OUT),
      .rdata(DATA_IN), .rd_n(RAM_READ_STROBE_N), .wr_n(RAM_WRITE_STROBE_N), .sel_n(RAM_SELECT_OUT_N),
      .req_n(DMA_REQUEST_OUT_N), .gnt_n(DMA_GRANT_IN_N));

   initial begin
      MCLK = 1'b0;
      forever #4 MCLK = ~MCLK;
   end

   always @(posedge MCLK) begin
      if (irq_clr) begin
         {s_cmd, s_zero, s_ill} <= 3'h0;
      end else begin
         s_cmd <= s_cmd | IRQ_CMD;
         s_zero <= s_zero | IRQ_INDEX_ZERO;
         s_ill <= s_ill | IRQ_ILLEGAL;
      end
      cyc++;
      if (cyc == 6000) begin
         num_errors++;
         end_of_test();
      end
   end

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Own accesses: address drive follows its enable and the host register read strobe stays low.
   always @(negedge MCLK) begin
      if (!DMA_ACKNOWLEDGE_OUT_N) begin
         chk(ADDR_OE, !ADDRESS_DRIVE_ENABLE_N);
         chk(REG_RD_STROBE, 1'b0);
      end
   end

   // One message: start, data words, end.
   task automatic msg(input logic [4:0] sa, input logic tx, bc, input logic [4:0] wc, input int n);
      @(negedge MCLK);
      irq_clr = 1'b1;
      while (!MSG_READY) @(negedge MCLK);
      {MSG_START, MSG_SUBADDR, MSG_TRANSMIT, MSG_BROADCAST, MSG_WORD_COUNT} = {1'b1, sa, tx, bc, wc};
      @(negedge MCLK);
      MSG_START = 1'b0;
      irq_clr = 1'b0;
      for (int i = 0; i < n; i++) begin
         while (!DW_READY) @(negedge MCLK);
         DW_REQ = 1'b1;
         DW_IN = 16'(16'h1111 * (i + 1) + 16'h0100 * nmsg);
         @(negedge MCLK);
         DW_REQ = 1'b0;
         while (!DW_DONE) @(negedge MCLK);
         dw_seen = DW_OUT;
      end
      while (!DW_READY) @(negedge MCLK);
      MSG_END = 1'b1;
      @(negedge MCLK);
      MSG_END = 1'b0;
      @(negedge MCLK);
      while (!MSG_READY) @(negedge MCLK);
      nmsg++;
   endtask

   task automatic end_of_test();
      if (num_errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      {HOST_CS_N, HOST_RD_N, HOST_WR_N, HOST_RAM_SELECT_IN_N} = 4'hF;
      {RT_BUSY, SUBSYSTEM_FAIL_IN, ILL_IRQ_ENABLE, TX_ACTIVE, RX_CHANNEL_B, MSG_START} = 6'h00;
      {MSG_TRANSMIT, MSG_BROADCAST, DW_REQ, MSG_END, MSG_ERR_IN, slow, ADDRESS_DRIVE_ENABLE_N} = 7'h00;
      irq_clr = 1'b1;
      {HOST_ADDR, MSG_SUBADDR, MSG_WORD_COUNT} = 14'h0000;
      {REG_RDATA, DESC_BASE, DW_IN} = {16'h5A5A, 32'h0};
      NRST = 1'b0;
      repeat (12) @(negedge MCLK);
      // Descriptors are loaded once the model has cleared its memory.
      {ram.mem[16], ram.mem[17], ram.mem[18]} = {16'h0182, 16'h0040, 16'h0080};
      {ram.mem[20], ram.mem[22], ram.mem[160]} = {16'h0001, 16'h00A0, 16'hBEEF};
      {ram.mem[24], ram.mem[25], ram.mem[26]} = {16'h0200, 16'h0050, 16'h0090};
      {ram.mem[32], ram.mem[33], ram.mem[34]} = {16'h0400, 16'h0060, 16'h00B0};
      NRST = 1'b1;
      {HOST_CS_N, HOST_RD_N, HOST_ADDR, HOST_RAM_SELECT_IN_N, TX_ACTIVE, RX_CHANNEL_B} = {2'b00, 4'hD, 3'b011};
      @(negedge MCLK);
      chk(REG_RD_STROBE, 1'b1);
      chk(REG_INDEX, 4'hD);
      chk(DATA_OE, 1'b1);
      chk(DATA_OUT, 16'h5A5A);
      chk(RAM_SELECT_OUT_N, 1'b0);
      chk(TRANSMIT_TIMER_ON, 1'b1);
      chk(ACTIVE_CHANNEL_FLAG, 1'b1);
      HOST_ADDR = 4'hE;
      @(negedge MCLK);
      chk(REG_RD_STROBE, 1'b0);
      {HOST_RD_N, HOST_WR_N, HOST_RAM_SELECT_IN_N, HOST_ADDR} = {3'b101, 4'h3};
      @(negedge MCLK);
      chk(REG_WR_STROBE, 1'b1);
      chk(RAM_WRITE_STROBE_N, 1'b0);
      {HOST_CS_N, HOST_RD_N, HOST_WR_N, HOST_RAM_SELECT_IN_N} = 4'hF;
      msg(5'd2, 1'b0, 1'b1, 5'd2, 2);
      chk(ram.mem[128], 16'h1111);
      chk(ram.mem[129], 16'h2222);
      chk(ram.mem[64] & 16'hFF00, 16'h4200);
      chk(ram.mem[16], 16'h0181);
      chk(ram.mem[17], 16'h0041);
      chk(ram.mem[18], 16'h0082);
      chk({s_cmd, s_zero}, 2'b10);
      SUBSYSTEM_FAIL_IN = 1'b1;
      msg(5'd2, 1'b0, 1'b0, 5'd1, 2);
      chk(ram.mem[130], 16'h1211);
      chk(ram.mem[131], 16'h0000);
      chk(ram.mem[65] & 16'hFF00, 16'hA100);
      chk({ram.mem[16], ram.mem[17], ram.mem[18]}, {16'h0180, 16'h0042, 16'h0082});
      chk({s_zero, STATUS_MSG_ERROR}, 2'b11);
      {SUBSYSTEM_FAIL_IN, slow, RT_BUSY, ADDRESS_DRIVE_ENABLE_N} = 4'b0111;
      fork
         begin
            repeat (20) @(negedge MCLK);
            chk(DMA_REQUEST_OUT_N, 1'b1);
            RT_BUSY = 1'b0;
         end
      join_none
      MSG_ERR_IN = 1'b0;
      msg(5'd2, 1'b0, 1'b0, 5'd1, 1);
      chk(ram.mem[130], 16'h1311);
      chk(ram.mem[131], 16'h0000);
      chk(ram.mem[66] & 16'hFF00, 16'h0100);
      chk({ram.mem[16], ram.mem[17], ram.mem[18]}, {16'h0180, 16'h0042, 16'h0082});
      {ILL_IRQ_ENABLE, ADDRESS_DRIVE_ENABLE_N} = 2'b10;
      msg(5'd3, 1'b0, 1'b0, 5'd1, 1);
      chk({s_ill, STATUS_MSG_ERROR}, 2'b11);
      chk(ram.mem[144], 16'h0000);
      chk(ram.mem[26], 16'h0090);
      chk(ram.mem[80] & 16'hFF00, 16'h2100);
      msg(5'd4, 1'b0, 1'b1, 5'd1, 1);
      chk({s_ill, STATUS_MSG_ERROR}, 2'b01);
      chk(ram.mem[96] & 16'hFF00, 16'h6100);
      chk(ram.mem[176], 16'h0000);
      // A host register read is held through the transmit message.
      {HOST_CS_N, HOST_RD_N, HOST_ADDR} = {2'b00, 4'h1};
      msg(5'd2, 1'b1, 1'b0, 5'd1, 1);
      chk(REG_RD_STROBE, 1'b1);
      {HOST_CS_N, HOST_RD_N} = 2'b11;
      chk(dw_seen, 16'hBEEF);
      chk(ram.mem[22], 16'h00A1);
      chk(ram.mem[20], 16'h0000);
      end_of_test();
   end
endmodule
